// >>> verilog/sr_receiver.v
// Receive half of an asynchronous serial port with wakeup and status flags,
// reached over an AHB-Lite slave port with zero wait states.
// Assumes a transmitter elsewhere feeds its two flags on this clock.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none
`include "sr_regs.vh"

module sr_receiver (
   // Clock and reset.
   input  wire        i_clock,
   input  wire        i_nrst,
   // AHB-Lite slave.
   input  wire        i_hsel,
   input  wire [31:0] i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire [31:0] i_hwdata,
   input  wire        i_hready,
   output reg  [31:0] o_hrdata,
   output wire        o_hreadyout,
   output wire        o_hresp,
   // Serial line.
   input  wire        i_rx_pin,
   // Events from neighbouring logic on this clock.
   input  wire        i_tx_buffer_empty,
   input  wire        i_tx_complete_flag,
   input  wire        i_break_detect,
   input  wire        i_parity_error,
   // Interrupt vectors.
   output reg         o_irq_tx,
   output reg         o_irq_rx,
   output reg         o_irq_err
);

   localparam ST_SEARCH = 2'b00;
   localparam ST_START  = 2'b01;
   localparam ST_DATA   = 2'b10;
   localparam ST_STOP   = 2'b11;

   // Majority of three votes.
   function maj3;
      input [2:0] v;
      begin
         maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
      end
   endfunction

   // Votes that do not all agree.
   function mixed3;
      input [2:0] v;
      begin
         mixed3 = (v != 3'b000) && (v != 3'b111);
      end
   endfunction

   reg  [7:0]  ctrl;
   reg  [12:0] baud;
   reg  [9:0]  ien;
   reg         rx_buffer_full, idle_f, or_f, nf_f, fe_f, pf_f, edge_f, brk_f;
   reg  [8:0]  rx_data;
   reg  [5:0]  seen;
   reg         idle_armed;
   reg  [1:0]  state;
   reg  [3:0]  rt;
   reg  [2:0]  hist;
   reg  [2:0]  votes;
   reg  [3:0]  bitcnt;
   reg  [8:0]  shifter;
   reg         noisy, fe_pend, stop2;
   reg  [7:0]  idle_cnt;
   reg         prev_line;
   reg         d_wr;
   reg  [7:0]  d_addr;
   reg  [31:0] rd_mux;
   wire        tick;
   wire        pin_sync;

   wire rx_on  = ctrl[`SR_C_ON];
   wire nine   = ctrl[`SR_C_NINE];
   wire two    = ctrl[`SR_C_TWO];
   wire sleep  = ctrl[`SR_C_SLEEP];
   wire wake_a = ctrl[`SR_C_WAKE];

   // Pin enters the clock domain before any logic sees it.
   sr_sync u_sync (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_async (i_rx_pin),
      .o_sync  (pin_sync)
   );

   sr_baud u_baud (
      .i_clock   (i_clock),
      .i_nrst    (i_nrst),
      .i_run     (rx_on),
      .i_divisor (baud),
      .o_tick    (tick)
   );

   wire line = pin_sync ^ ctrl[`SR_C_INV];

   // Bus phases: the slave never stalls and always answers OKAY.
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   wire acc    = i_hsel & i_htrans[1] & i_hready;
   wire rd_acc = acc & ~i_hwrite;
   wire wr_acc = acc & i_hwrite;
   wire rd_s1  = rd_acc && i_haddr[7:0] == `SR_A_STAT1;
   wire rd_dat = rd_acc && i_haddr[7:0] == `SR_A_DATA;
   wire wr_ctl = d_wr && d_addr == `SR_A_CTRL;
   wire wr_s2  = d_wr && d_addr == `SR_A_STAT2;

   // Writes land in the data phase, one cycle after the address phase.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         d_wr   <= 1'b0;
         d_addr <= 8'h00;
      end else begin
         d_wr   <= wr_acc;
         d_addr <= i_haddr[7:0];
      end
   end

   // Sample slots and the decision point of each bit.
   wire s_tick  = tick & rx_on;
   wire vote_rt = (rt == 4'h8) || (rt == 4'h9) || (rt == 4'hA);
   wire start_rt = (rt == 4'h3) || (rt == 4'h5) || (rt == 4'h7);
   wire decide  = s_tick && rt == 4'hA;
   wire [2:0] v_now = {votes[1:0], line};
   wire bit_val = maj3(v_now);
   wire fall = s_tick && hist == 3'b111 && !line;
   wire last_data = bitcnt == (nine ? 4'h8 : 4'h7);
   wire last_stop = !two || stop2;
   // Character as it stands after the final shift.
   wire [8:0] full_sh = {bit_val, shifter[8:1]};
   wire [8:0] char_now = nine ? shifter : {1'b0, shifter[8:1]};

   // address mark in the top bit(s)
   wire addr_hit = state == ST_DATA && decide && last_data && wake_a && sleep &&
                   bit_val && (!two || shifter[8]);

   // Frame end: last stop bit decided.
   wire frame_end = state == ST_STOP && decide && last_stop;
   wire frame_fe  = fe_pend | ~bit_val;
   wire is_break  = frame_fe && char_now == 9'h000;
   wire xfer_ok   = frame_end && !sleep && !fe_f;
   wire set_rx_buffer_full  = xfer_ok && !rx_buffer_full;
   wire set_or    = xfer_ok && rx_buffer_full;

   // Receiver sequencer: search, start check, data bits, stop bits.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state   <= ST_SEARCH;
         rt      <= 4'h0;
         hist    <= 3'b111;
         votes   <= 3'b000;
         bitcnt  <= 4'h0;
         shifter <= 9'h000;
         noisy   <= 1'b0;
         fe_pend <= 1'b0;
         stop2   <= 1'b0;
      end else if (!rx_on) begin
         state <= ST_SEARCH;
         rt    <= 4'h0;
         hist  <= 3'b111;
      end else if (s_tick) begin
         hist <= {hist[1:0], line};
         rt   <= rt + 4'h1;
         if (start_rt || vote_rt) begin
            votes <= v_now;
         end
         case (state)
            ST_SEARCH: begin
               if (fall) begin
                  state <= ST_START;
                  rt    <= 4'h2;
                  noisy <= 1'b0;
                  votes <= 3'b000;
               end
            end
            ST_START: begin
               if (rt == 4'h7) begin
                  votes <= 3'b000;
                  if (maj3(v_now)) begin
                     state <= ST_SEARCH;
                  end else begin
                     noisy <= mixed3(v_now);
                  end
               end
               // late start samples only mark noise
               if (decide) begin
                  noisy   <= noisy | (v_now != 3'b000);
                  state   <= ST_DATA;
                  bitcnt  <= 4'h0;
                  fe_pend <= 1'b0;
                  stop2   <= 1'b0;
               end
            end
            ST_DATA: begin
               if (fall) begin
                  rt <= 4'h2;
               end
               if (decide) begin
                  shifter <= full_sh;
                  noisy   <= noisy | mixed3(v_now);
                  bitcnt  <= bitcnt + 4'h1;
                  if (last_data) begin
                     state <= ST_STOP;
                  end
               end
            end
            default: begin
               if (fall) begin
                  rt <= 4'h2;
               end
               if (decide) begin
                  noisy   <= noisy | mixed3(v_now);
                  fe_pend <= frame_fe;
                  stop2   <= 1'b1;
                  if (last_stop) begin
                     state <= ST_SEARCH;
                     if (frame_fe && !is_break) begin
                        hist <= 3'b111;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Idle counter in sixteenths; threshold is one whole frame.
   wire [3:0] frame_bits = `SR_FRAME_BASE + {3'b000, nine} + {3'b000, two};
   wire [7:0] idle_max   = {frame_bits, 4'h0};
   wire idle_hit = s_tick && line && idle_cnt == idle_max - 8'h01 &&
                   !(state == ST_START) && !(ctrl[`SR_C_ILT] && state != ST_SEARCH);
   wire idle_wake = idle_hit && sleep && !wake_a;
   // waking idle reported only when enabled
   wire set_idle  = idle_hit && idle_armed && (!sleep || ctrl[`SR_C_IDLE_DURING_SLEEP_REPORT]);

   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         idle_cnt <= 8'h00;
      end else if (!rx_on || (s_tick && !line)) begin
         idle_cnt <= 8'h00;
      end else if (s_tick) begin
         if (state == ST_START || (ctrl[`SR_C_ILT] && state != ST_SEARCH)) begin
            idle_cnt <= 8'h00;
         end else if (idle_cnt != idle_max) begin
            idle_cnt <= idle_cnt + 8'h01;
         end
      end
   end

   // Control, divisor and enable registers; sleep also clears itself.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl <= `SR_CTRL_RST;
         baud <= `SR_BAUD_RST;
         ien  <= `SR_IEN_RST;
      end else begin
         if (wr_ctl) begin
            ctrl <= i_hwdata[7:0];
         end else if (addr_hit || idle_wake) begin
            ctrl[`SR_C_SLEEP] <= 1'b0;
         end
         if (d_wr && d_addr == `SR_A_BAUD) begin
            baud <= i_hwdata[12:0];
         end
         if (d_wr && d_addr == `SR_A_IEN) begin
            ien <= i_hwdata[9:0];
         end
      end
   end

   // status read arms, data read clears
   // Flags seen set at the status read are the ones the data read clears.
   wire [5:0] s1_now = {pf_f, fe_f, nf_f, or_f, idle_f, rx_buffer_full};
   wire [5:0] clr    = rd_dat ? seen : 6'h00;

   // Status flags: a set in the clearing cycle wins.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         seen       <= 6'h00;
         rx_buffer_full       <= 1'b0;
         idle_f     <= 1'b0;
         or_f       <= 1'b0;
         nf_f       <= 1'b0;
         fe_f       <= 1'b0;
         pf_f       <= 1'b0;
         edge_f     <= 1'b0;
         brk_f      <= 1'b0;
         idle_armed <= 1'b1;
         rx_data    <= 9'h000;
         prev_line  <= 1'b1;
      end else begin
         prev_line <= line;
         if (rd_s1) begin
            seen <= s1_now;
         end else if (rd_dat) begin
            seen <= 6'h00;
         end
         // ninth bit kept with the character
         if (set_rx_buffer_full) begin
            rx_data <= char_now;
         end
         rx_buffer_full   <= set_rx_buffer_full | (rx_buffer_full & ~clr[0]);
         idle_f <= set_idle | (idle_f & ~clr[1]);
         or_f   <= set_or | (or_f & ~clr[2]);
         nf_f   <= (set_rx_buffer_full & (noisy | mixed3(v_now))) | (nf_f & ~clr[3]);
         fe_f   <= (set_rx_buffer_full & frame_fe) | (fe_f & ~clr[4]);
         pf_f   <= (set_rx_buffer_full & i_parity_error) | (pf_f & ~clr[5]);
         if (set_rx_buffer_full) begin
            idle_armed <= 1'b1;
         end else if (set_idle) begin
            idle_armed <= 1'b0;
         end
         // edge flag, write one to clear
         edge_f <= (rx_on & prev_line & ~line) |
                   (edge_f & ~(wr_s2 & i_hwdata[`SR_S2_EDGE]));
         brk_f  <= (rx_on & i_break_detect) |
                   (brk_f & ~(wr_s2 & i_hwdata[`SR_S2_BRK]));
      end
   end

   // Read data mux; unmapped offsets read as zero.
   always @* begin
      rd_mux = 32'h0000_0000;
      case (i_haddr[7:0])
         `SR_A_CTRL:  rd_mux[7:0] = ctrl;
         `SR_A_BAUD:  rd_mux[12:0] = baud;
         `SR_A_IEN:   rd_mux[9:0] = ien;
         `SR_A_STAT1: rd_mux[7:0] = {s1_now, i_tx_complete_flag, i_tx_buffer_empty};
         `SR_A_STAT2: rd_mux[1:0] = {brk_f, edge_f};
         `SR_A_DATA:  rd_mux[8:0] = rx_data;
         default:     rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is captured at the address phase and held for the data phase.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (rd_acc) begin
         o_hrdata <= rd_mux;
      end
   end

   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq_tx  <= 1'b0;
         o_irq_rx  <= 1'b0;
         o_irq_err <= 1'b0;
      end else begin
         o_irq_tx  <= (i_tx_buffer_empty & ien[0]) | (i_tx_complete_flag & ien[1]);
         o_irq_rx  <= (rx_buffer_full & ien[2]) | (idle_f & ien[3]) | (edge_f & ien[4]) |
                      (brk_f & ien[5]);
         o_irq_err <= (or_f & ien[6]) | (nf_f & ien[7]) | (fe_f & ien[8]) |
                      (pf_f & ien[9]);
      end
   end

endmodule

`default_nettype wire

// >>> verilog/sr_regs.vh
// Register map, field positions, reset values and sampling constants
// for the serial receiver. Assumes byte addresses on a 32-bit AHB-Lite bus.
`ifndef SR_REGS_VH
`define SR_REGS_VH

// Register byte offsets.
`define SR_A_CTRL     8'h00
`define SR_A_BAUD     8'h04
`define SR_A_IEN      8'h08
`define SR_A_STAT1    8'h0C
`define SR_A_STAT2    8'h10
`define SR_A_DATA     8'h14

// Control register fields.
`define SR_C_ON       0
`define SR_C_INV      1
`define SR_C_NINE     2
`define SR_C_TWO      3
`define SR_C_WAKE     4
`define SR_C_ILT      5
`define SR_C_IDLE_DURING_SLEEP_REPORT    6
`define SR_C_SLEEP    7
`define SR_CTRL_RST   8'h00

// Interrupt enable fields, one per source.
`define SR_IEN_RST    10'h000

// First status register fields.
`define SR_S1_TX_BUFFER_EMPTY    0
`define SR_S1_TC      1
`define SR_S1_RX_BUFFER_FULL    2
`define SR_S1_IDLE    3
`define SR_S1_OR      4
`define SR_S1_NF      5
`define SR_S1_FE      6
`define SR_S1_PF      7

// Second status register fields, write one to clear.
`define SR_S2_EDGE    0
`define SR_S2_BRK     1

// Data register field for the ninth bit.
`define SR_D_BIT8     8

// Bus clock cycles per sixteenth of a bit, after reset.
`define SR_BAUD_RST   13'h0010
// Sixteenths per bit and bits in the shortest frame.
`define SR_OVS_SHIFT  4
`define SR_FRAME_BASE 4'hA

`endif

// >>> verilog/sr_sync.v
// Two-flop synchroniser for the serial input pin.
// Assumes the pin idles high, so both stages reset high.
`default_nettype none

module sr_sync (
   // Clock and reset.
   input  wire i_clock,
   input  wire i_nrst,
   // Asynchronous level in, synchronised level out.
   input  wire i_async,
   output wire o_sync
);

   reg stage1;
   reg stage2;

   // The first stage feeds only the second one.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
      end else begin
         stage1 <= i_async;
         stage2 <= stage1;
      end
   end

   assign o_sync = stage2;

endmodule

`default_nettype wire

// >>> verilog/sr_baud.v
// Divider that makes the sixteen-times-baud sample tick from the bus clock.
// Assumes a divisor from a register on the same clock; zero stops the tick.
`default_nettype none

module sr_baud (
   // Clock and reset.
   input  wire        i_clock,
   input  wire        i_nrst,
   // Run control and divisor.
   input  wire        i_run,
   input  wire [12:0] i_divisor,
   // One-cycle sample tick.
   output reg         o_tick
);

   reg [12:0] count;

   // Count up to the divisor; a stopped divider restarts from zero.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         count  <= 13'h0000;
         o_tick <= 1'b0;
      end else if (!i_run || i_divisor == 13'h0000) begin
         count  <= 13'h0000;
         o_tick <= 1'b0;
      end else if (count >= i_divisor - 13'h0001) begin
         count  <= 13'h0000;
         o_tick <= 1'b1;
      end else begin
         count  <= count + 13'h0001;
         o_tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// >>> tb/sr_receiver_props.sv
// Checker for the serial receiver's bus answers and transmit interrupt output.
// Assumes one clock domain and a zero-wait-state slave.
`default_nettype none
`include "sr_regs.vh"

module sr_receiver_props (
   // Clock and reset.
   input wire        i_clock,
   input wire        i_nrst,
   // Bus request side.
   input wire        i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0]  i_htrans,
   input wire        i_hwrite,
   input wire        i_hready,
   // Transmitter events.
   input wire        i_tx_buffer_empty,
   input wire        i_tx_complete_flag,
   // Design outputs.
   input wire [31:0] o_hrdata,
   input wire        o_hreadyout,
   input wire        o_hresp,
   input wire        o_irq_tx,
   input wire        o_irq_rx,
   input wire        o_irq_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       rd_take;
   logic [7:0] rd_addr;
   logic       tx_cause;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   // A read is taken only when select, transfer type and ready all stand.
   assign rd_take  = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
   assign rd_addr  = i_haddr[7:0];
   assign tx_cause = i_tx_buffer_empty || i_tx_complete_flag;

   bus_ready_a: assert property (o_hreadyout)
      else $error("Slave inserted a wait state.");
   bus_okay_a: assert property (!o_hresp)
      else $error("Slave answered with an error.");
   unmapped_zero_a: assert property (rd_take && rd_addr == 8'h18 |=> o_hrdata == 32'h0)
      else $error("Unmapped read returned nonzero data.");
   rdata_hold_a: assert property (!rd_take |=> $stable(o_hrdata))
      else $error("Read data changed without a read.");
   stat_tx_a: assert property (rd_take && rd_addr == `SR_A_STAT1 && $stable(tx_cause)
      |=> o_hrdata[1:0] == {$past(i_tx_complete_flag), $past(i_tx_buffer_empty)})
      else $error("Status shows wrong transmitter bits.");
   stat_upper_a: assert property (rd_take && rd_addr == `SR_A_STAT1 |=> o_hrdata[31:8] == 24'h0)
      else $error("Status upper bits not zero.");
   data_upper_a: assert property (rd_take && rd_addr == `SR_A_DATA |=> o_hrdata[31:9] == 23'h0)
      else $error("Data upper bits not zero.");
   tx_irq_cause_a: assert property (o_irq_tx |-> $past(tx_cause) || $past(tx_cause, 2))
      else $error("Transmit interrupt without a cause.");
   tx_irq_drop_a: assert property (!tx_cause [*3] |=> !o_irq_tx)
      else $error("Transmit interrupt stayed without a cause.");

   // Main scenarios that the bench should reach.
   cover property (rd_take && rd_addr == `SR_A_DATA);
   cover property (o_irq_rx);
   cover property (o_irq_err);
   cover property (o_irq_tx);
endmodule

bind sr_receiver sr_receiver_props u_sr_receiver_props (
   .i_clock(i_clock), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
   .i_tx_buffer_empty(i_tx_buffer_empty), .i_tx_complete_flag(i_tx_complete_flag),
   .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .o_irq_tx(o_irq_tx), .o_irq_rx(o_irq_rx), .o_irq_err(o_irq_err));
`default_nettype wire

// >>> tb/sr_tx_model.sv
// Behavioural remote transmitter that sends one serial frame per call.
// Assumes the bit time is a whole number of bus clock cycles.
`default_nettype none

module sr_tx_model #(
   parameter int BIT_CLKS = 32
) (
   // Clock that times the bits.
   input  wire logic i_clock,
   // Serial line, driven high between frames.
   output var  logic o_line
);
   timeunit 1ns;
   timeprecision 1ps;

   initial o_line = 1'b1;

   // Frame shape is built here.
   // A glitch in bit g or a low stop bit goes out only when the bench asks for it.
   task automatic send(input logic [8:0] d, input logic nine, input int g, input logic ok);
      logic [11:0] f;
      int          n;
      f = nine ? {2'b11, d, 1'b0} : {3'b111, d[7:0], 1'b0};
      n = nine ? 11 : 10;
      f[n - 1] = ok;
      for (int i = 0; i < n; i++) begin
         for (int c = 0; c < BIT_CLKS; c++) begin
            @(posedge i_clock);
            // Cycles 16 and 17 reach the receiver on the middle vote sample of the bit.
            o_line <= (i == g && (c == 16 || c == 17)) ? ~f[i] : f[i];
         end
      end
      @(posedge i_clock);
      o_line <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the serial receiver over AHB-Lite.
// Assumes the partner model drives the line from the bench clock.
`default_nettype none
`include "sr_regs.vh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ST1 = `SR_A_STAT1;
   localparam logic [7:0] ST2 = `SR_A_STAT2;
   localparam logic [7:0] DAT = `SR_A_DATA;
   localparam logic [7:0] CTL = `SR_A_CTRL;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        tx_empty = 1'b0;
   logic        tx_done = 1'b0;
   logic        brk = 1'b0;
   logic        par = 1'b0;
   logic [31:0] rd;
   wire  [31:0] hrdata;
   wire         hready;
   wire         line;
   wire         irq_tx;
   wire         irq_rx;
   wire         irq_err;
   int          failures = 0;
   int          compares = 0;

   // A bit is 16 ticks of 2 cycles, so the model uses 32 cycles per bit.
   sr_tx_model #(.BIT_CLKS(32)) u_sr_tx_model (.i_clock(clock), .o_line(line));

   sr_receiver u_sr_receiver (
      .i_clock(clock), .i_nrst(nrst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_rx_pin(line),
      .i_tx_buffer_empty(tx_empty), .i_tx_complete_flag(tx_done), .i_break_detect(brk),
      .i_parity_error(par), .o_irq_tx(irq_tx), .o_irq_rx(irq_rx), .o_irq_err(irq_err));

   always #12.5 clock = ~clock;

   // One single transfer; each phase is held until ready is sampled high.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, rd & m);
   endtask

   // Flags land before the stop bit ends; four cycles let them settle.
   task automatic rx(input logic [8:0] d, input logic nine, input int g, input logic ok);
      u_sr_tx_model.send(d, nine, g, ok);
      repeat (4) @(posedge clock);
   endtask

   task automatic test_reset();
      logic [7:0] addr [7] = '{CTL, 8'h04, 8'h08, ST1, ST2, DAT, 8'h18};
      for (int i = 0; i < 7; i++) begin
         rchk("reset value", addr[i], 32'hFFFFFFFF, (i == 1) ? 32'h10 : 32'h0);
      end
      bus(1'b1, 8'h04, 32'h2);
      bus(1'b1, 8'h08, 32'h3C7);
      bus(1'b1, CTL, 32'h1);
      rchk("ctrl", CTL, 32'hFF, 32'h01);
      tx_empty <= 1'b1;
      repeat (4) @(posedge clock);
      chk("irq tx empty", 32'h1, {31'h0, irq_tx});
      tx_empty <= 1'b0;
      tx_done  <= 1'b1;
      repeat (4) @(posedge clock);
      chk("irq tx done", 32'h1, {31'h0, irq_tx});
      tx_done <= 1'b0;
      $display("test_reset done");
   endtask

   task automatic test_receive();
      rx(9'h0A5, 1'b0, -1, 1'b1);
      chk("irq rx", 32'h1, {31'h0, irq_rx});
      rchk("rx full", ST1, 32'hF4, 32'h04);
      rchk("data", DAT, 32'h1FF, 32'hA5);
      rchk("cleared", ST1, 32'hF4, 32'h0);
      rx(9'h03C, 1'b0, -1, 1'b1);
      rx(9'h0C3, 1'b0, -1, 1'b1);
      rchk("data kept", DAT, 32'h1FF, 32'h3C);
      rchk("overrun", ST1, 32'hF4, 32'h14);
      chk("irq err", 32'h1, {31'h0, irq_err});
      rchk("data again", DAT, 32'h1FF, 32'h3C);
      rchk("cleared", ST1, 32'hF4, 32'h0);
      $display("test_receive done");
   endtask

   task automatic test_errors();
      rx(9'h0A5, 1'b0, 2, 1'b1);
      rchk("noise", ST1, 32'hF4, 32'h24);
      rchk("voted data", DAT, 32'h1FF, 32'hA5);
      par <= 1'b1;
      rx(9'h00F, 1'b0, -1, 1'b0);
      par <= 1'b0;
      rchk("framing", ST1, 32'hF4, 32'hC4);
      rchk("frame data", DAT, 32'h1FF, 32'h0F);
      rchk("cleared", ST1, 32'hF4, 32'h0);
      // The low stop bit looks like a new start bit, so a frame of ones with a
      // noisy start follows; it lands once the framing flag is gone.
      repeat (320) @(posedge clock);
      rchk("restart", ST1, 32'hF4, 32'h24);
      rchk("restart data", DAT, 32'h1FF, 32'hFF);
      rchk("restart cleared", ST1, 32'hF4, 32'h0);
      $display("test_errors done");
   endtask

   task automatic test_wake();
      bus(1'b1, CTL, 32'h95);
      rx(9'h055, 1'b1, -1, 1'b1);
      rchk("asleep", ST1, 32'hF4, 32'h0);
      rx(9'h1C3, 1'b1, -1, 1'b1);
      rchk("mark", ST1, 32'hF4, 32'h04);
      rchk("ninth bit", DAT, 32'h1FF, 32'h1C3);
      rchk("awake", CTL, 32'hFF, 32'h15);
      $display("test_wake done");
   endtask

   task automatic test_edge();
      rchk("edge", ST2, 32'h3, 32'h1);
      brk <= 1'b1;
      @(posedge clock);
      brk <= 1'b0;
      rchk("break", ST2, 32'h3, 32'h3);
      bus(1'b1, ST2, 32'h1);
      rchk("edge cleared", ST2, 32'h3, 32'h2);
      bus(1'b1, ST2, 32'h2);
      rchk("all cleared", ST2, 32'h3, 32'h0);
      // A switched-off receiver ignores a whole frame, its edges included.
      bus(1'b1, CTL, 32'h0);
      rx(9'h055, 1'b0, -1, 1'b1);
      rchk("off edge", ST2, 32'h3, 32'h0);
      rchk("off frame", ST1, 32'hF4, 32'h0);
      $display("test_edge done");
   endtask

   // Counting starts after the start bit, so nine idle bits are seen when the frame ends.
   task automatic test_idle();
      bus(1'b1, CTL, 32'h81);
      rx(9'h0FF, 1'b0, -1, 1'b1);
      rchk("still asleep", CTL, 32'h80, 32'h80);
      repeat (64) @(posedge clock);
      rchk("idle wake", CTL, 32'h80, 32'h0);
      // Counting from the stop bit keeps the receiver asleep nine bit times longer.
      bus(1'b1, CTL, 32'hA1);
      rx(9'h0FF, 1'b0, -1, 1'b1);
      repeat (64) @(posedge clock);
      rchk("late count", CTL, 32'h80, 32'h80);
      repeat (288) @(posedge clock);
      rchk("late wake", CTL, 32'h80, 32'h0);
      $display("test_idle done");
   endtask

   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence after the reset hold.
   initial begin
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      test_reset();
      test_receive();
      test_errors();
      test_wake();
      test_edge();
      test_idle();
      end_of_test();
   end

   // The tests need about 4200 cycles; a hang is cut well beyond that.
   initial begin
      repeat (60000) @(posedge clock);
      failures++;
      end_of_test();
   end
endmodule
`default_nettype wire
